// ---- rtl/ext_irq_edge_priority_ctrl.sv ----
// Interrupt control slice: serial enable, second priority select, external edge
// selection for two pin groups, group flags and a two-level priority arbiter.
// Assumes a same-clock special-function register port and a core that acks grants.
//
// Overview of operation
// [RULE1] Serial unit request reaches the core only while its enable bit 0 is set.
// [RULE2] Priority bit 4 selects low or high level for the touch-sense request.
// [RULE3] Priority bit 3 selects low or high level for the group B request.
// [RULE4] Priority bit 2 selects low or high level for the base tick request.
// [RULE5] Priority bit 1 selects low or high level for the pulse-width request.
// [RULE6] Priority bit 0 selects low or high level for the serial unit request.
// [RULE7] Group A flag sets on an enabled edge, clears when the core responds.
// [RULE8] Group A falling enables bits 3..1 arm falling edges on pins 1..3.
// [RULE9] Group A rising enables bits 3..1 arm rising edges on pins 1..3.
// [RULE10] Group B falling enables bits 1, 4, 5 arm falling edges on those pins.
// [RULE11] Group B rising enables bits 1, 4, 5 arm rising edges on those pins.
// [RULE12] Both enables set on a pin means either edge requests an interrupt.
// [RULE13] High level preempts low service; equal or lower waits for return.
// [RULE14] Among equal-level pending requests the smallest query number is granted.
// [RULE15] Pins are synchronised first; one enabled edge gives exactly one pulse.
module ext_irq_edge_priority_ctrl (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic [2:0] ext_group_a_pin_i,
  input  wire logic [2:0] ext_group_b_pin_i,
  input  wire logic       serial_unit_req_i,
  input  wire logic       pulse_width_req_i,
  input  wire logic       base_tick_req_i,
  input  wire logic       touch_sense_req_i,
  input  wire logic       ext_group_a_high_i,
  input  wire logic       irq_ack_i,
  input  wire logic       irq_return_i,
  output logic            irq_req_o,
  output logic      [2:0] irq_id_o,
  output logic            irq_high_o,
  output logic            ext_group_a_request_flag_o
);
  import irq_ctrl_pkg::*;

  logic [7:0] irq_enable_2;
  logic [7:0] prio_select_2;
  logic [7:0] a_fall_en;
  logic [7:0] a_rise_en;
  logic [7:0] b_fall_en;
  logic [7:0] b_rise_en;
  logic       ext_group_a_request_flag;
  logic       ext_group_b_pending;
  service_e   state;
  logic [5:0] pend;
  logic [5:0] high_map;
  logic [5:0] hi_pend;
  logic [5:0] lo_pend;
  logic       next_req;
  logic [2:0] next_id;
  logic       next_high;
  logic       ack_a;
  logic       ack_b;
  logic       sw_write_flag;
  logic [7:0] next_rdata;

  ext_edge_if edge_bus ();

  // ---------------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------------
  assign edge_bus.pins    = {ext_group_b_pin_i, ext_group_a_pin_i};
  assign edge_bus.rise_en = {b_rise_en[B_PIN5_BIT], b_rise_en[B_PIN4_BIT], b_rise_en[B_PIN1_BIT], // RULE11
                             a_rise_en[A_PIN3_BIT], a_rise_en[A_PIN2_BIT], a_rise_en[A_PIN1_BIT]}; // RULE9
  assign edge_bus.fall_en = {b_fall_en[B_PIN5_BIT], b_fall_en[B_PIN4_BIT], b_fall_en[B_PIN1_BIT], // RULE10
                             a_fall_en[A_PIN3_BIT], a_fall_en[A_PIN2_BIT], a_fall_en[A_PIN1_BIT]}; // RULE8

  ext_edge_detect u_edge (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .edge_bus (edge_bus.detector)
  );

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_enable_2  <= RESET_REG8;
      prio_select_2 <= RESET_REG8;
      a_fall_en     <= RESET_REG8;
      a_rise_en     <= RESET_REG8;
      b_fall_en     <= RESET_REG8;
      b_rise_en     <= RESET_REG8;
    end else if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        ADDR_IRQ_ENABLE_2:  irq_enable_2  <= sfr_wdata_i & MASK_IRQ_ENABLE_2;
        ADDR_PRIO_SELECT_2: prio_select_2 <= sfr_wdata_i & MASK_PRIO_SELECT_2;
        ADDR_A_FALL_EN:     a_fall_en     <= sfr_wdata_i & MASK_A_EDGE;
        ADDR_A_RISE_EN:     a_rise_en     <= sfr_wdata_i & MASK_A_EDGE;
        ADDR_B_FALL_EN:     b_fall_en     <= sfr_wdata_i & MASK_B_EDGE;
        ADDR_B_RISE_EN:     b_rise_en     <= sfr_wdata_i & MASK_B_EDGE;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Group flags
  // ---------------------------------------------------------------------------
  assign ack_a         = irq_ack_i && irq_req_o && (irq_id_o == ID_EXT_A);
  assign ack_b         = irq_ack_i && irq_req_o && (irq_id_o == ID_EXT_B);
  assign sw_write_flag = sfr_wr_i && (sfr_addr_i == ADDR_TIMER_EXT_CTRL);

  // A new edge in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_group_a_request_flag <= 1'b0;
    end else if (|edge_bus.req[2:0]) begin
      ext_group_a_request_flag <= 1'b1; // RULE7
    end else if (ack_a) begin
      ext_group_a_request_flag <= 1'b0; // RULE7
    end else if (sw_write_flag) begin
      ext_group_a_request_flag <= sfr_wdata_i[EXT_A_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_group_b_pending <= 1'b0;
    end else if (|edge_bus.req[5:3]) begin
      ext_group_b_pending <= 1'b1;
    end else if (ack_b) begin
      ext_group_b_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ext_group_a_request_flag_o <= 1'b0;
    end else begin
      ext_group_a_request_flag_o <= ext_group_a_request_flag;
    end
  end

  // ---------------------------------------------------------------------------
  // Arbitration
  // ---------------------------------------------------------------------------
  function automatic logic [2:0] first_set(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  assign pend = {touch_sense_req_i, ext_group_b_pending, base_tick_req_i, pulse_width_req_i,
                 serial_unit_req_i & irq_enable_2[SERIAL_EN_BIT], // RULE1
                 ext_group_a_request_flag};
  assign high_map = {prio_select_2[TOUCH_PRIO_BIT],   // RULE2
                     prio_select_2[EXT_B_PRIO_BIT],   // RULE3
                     prio_select_2[BASE_PRIO_BIT],    // RULE4
                     prio_select_2[PWM_PRIO_BIT],     // RULE5
                     prio_select_2[SERIAL_PRIO_BIT],  // RULE6
                     ext_group_a_high_i};
  assign hi_pend = pend & high_map;
  assign lo_pend = pend & ~high_map;

  always_comb begin
    next_req  = 1'b0;
    next_id   = 3'h0;
    next_high = 1'b0;
    // A high request may nest over low service; low waits for an idle core
    if ((|hi_pend) && (state == SVC_IDLE || state == SVC_LOW)) begin // RULE13
      next_req  = 1'b1;
      next_id   = first_set(hi_pend); // RULE14
      next_high = 1'b1;
    end else if ((|lo_pend) && state == SVC_IDLE) begin // RULE13
      next_req  = 1'b1;
      next_id   = first_set(lo_pend); // RULE14
    end
  end

  // Dropped in the ack cycle so a stale grant is never shown twice
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_req_o  <= 1'b0;
      irq_id_o   <= 3'h0;
      irq_high_o <= 1'b0;
    end else begin
      irq_req_o  <= next_req & ~irq_ack_i;
      irq_id_o   <= next_id;
      irq_high_o <= next_high;
    end
  end

  // ---------------------------------------------------------------------------
  // Service level tracking
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= SVC_IDLE;
    end else if (irq_return_i) begin
      unique case (state)
        SVC_NESTED: state <= SVC_LOW;
        SVC_HIGH:   state <= SVC_IDLE;
        SVC_LOW:    state <= SVC_IDLE;
        SVC_IDLE:   state <= SVC_IDLE;
        default:    state <= SVC_IDLE;
      endcase
    end else if (irq_ack_i && irq_req_o) begin
      unique case (state)
        SVC_IDLE:   state <= irq_high_o ? SVC_HIGH : SVC_LOW;
        SVC_LOW:    state <= irq_high_o ? SVC_NESTED : SVC_LOW;
        SVC_HIGH:   state <= SVC_HIGH;
        SVC_NESTED: state <= SVC_NESTED;
        default:    state <= SVC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    unique case (sfr_addr_i)
      ADDR_TIMER_EXT_CTRL: next_rdata[EXT_A_FLAG_BIT] = ext_group_a_request_flag;
      ADDR_IRQ_ENABLE_2:   next_rdata = irq_enable_2;
      ADDR_PRIO_SELECT_2:  next_rdata = prio_select_2;
      ADDR_A_FALL_EN:      next_rdata = a_fall_en;
      ADDR_A_RISE_EN:      next_rdata = a_rise_en;
      ADDR_B_FALL_EN:      next_rdata = b_fall_en;
      ADDR_B_RISE_EN:      next_rdata = b_rise_en;
      default:             next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= next_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  serial_gate_a: assert property ( // RULE1
    !$past(irq_enable_2[SERIAL_EN_BIT]) |-> !(irq_req_o && irq_id_o == ID_SERIAL))
    else $error("serial request granted while disabled");
  touch_level_a: assert property ( // RULE2
    irq_req_o && irq_id_o == ID_TOUCH |-> irq_high_o == $past(prio_select_2[TOUCH_PRIO_BIT]))
    else $error("touch-sense grant at wrong level");
  group_b_level_a: assert property ( // RULE3
    irq_req_o && irq_id_o == ID_EXT_B |-> irq_high_o == $past(prio_select_2[EXT_B_PRIO_BIT]))
    else $error("group B grant at wrong level");
  base_level_a: assert property ( // RULE4
    irq_req_o && irq_id_o == ID_BASE |-> irq_high_o == $past(prio_select_2[BASE_PRIO_BIT]))
    else $error("base tick grant at wrong level");
  pwm_level_a: assert property ( // RULE5
    irq_req_o && irq_id_o == ID_PWM |-> irq_high_o == $past(prio_select_2[PWM_PRIO_BIT]))
    else $error("pulse-width grant at wrong level");
  serial_level_a: assert property ( // RULE6
    irq_req_o && irq_id_o == ID_SERIAL |-> irq_high_o == $past(prio_select_2[SERIAL_PRIO_BIT]))
    else $error("serial grant at wrong level");
  flag_set_a: assert property ( // RULE7
    |edge_bus.req[2:0] |=> ext_group_a_request_flag ##1 ext_group_a_request_flag_o)
    else $error("group A edge did not set the flag");
  flag_clear_a: assert property ( // RULE7
    ack_a && !(|edge_bus.req[2:0]) |=> !ext_group_a_request_flag)
    else $error("group A flag not cleared on response");
  no_nest_a: assert property ( // RULE13
    $past(state == SVC_HIGH || state == SVC_NESTED) |-> !irq_req_o)
    else $error("request shown during high-level service");
  preempt_a: assert property ( // RULE13
    $past(state == SVC_LOW) && irq_req_o |-> irq_high_o)
    else $error("low request shown during low-level service");
  query_order_a: assert property ( // RULE14
    irq_req_o |-> ((irq_high_o ? $past(hi_pend) : $past(lo_pend)) & ((6'h01 << irq_id_o) - 6'h01)) == 6'h00)
    else $error("larger query number granted before a smaller one");

endmodule

// ---- common/irq_ctrl_pkg.sv ----
// Constants for the external-edge and priority slice of the interrupt controller.
// Assumes an 8-bit special-function register port and one system clock.
package irq_ctrl_pkg;

  // ---------------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_EXT_CTRL = 8'h88;
  localparam logic [7:0] ADDR_IRQ_ENABLE_2   = 8'ha9;
  localparam logic [7:0] ADDR_PRIO_SELECT_2  = 8'hb9;
  localparam logic [7:0] ADDR_A_FALL_EN      = 8'hba;
  localparam logic [7:0] ADDR_A_RISE_EN      = 8'hbb;
  localparam logic [7:0] ADDR_B_FALL_EN      = 8'hc6;
  localparam logic [7:0] ADDR_B_RISE_EN      = 8'hc7;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int SERIAL_EN_BIT     = 0;
  localparam int TOUCH_PRIO_BIT    = 4;
  localparam int EXT_B_PRIO_BIT    = 3;
  localparam int BASE_PRIO_BIT     = 2;
  localparam int PWM_PRIO_BIT      = 1;
  localparam int SERIAL_PRIO_BIT   = 0;
  localparam int EXT_A_FLAG_BIT    = 1;
  localparam int A_PIN1_BIT        = 1;
  localparam int A_PIN2_BIT        = 2;
  localparam int A_PIN3_BIT        = 3;
  localparam int B_PIN1_BIT        = 1;
  localparam int B_PIN4_BIT        = 4;
  localparam int B_PIN5_BIT        = 5;

  // Writable bits of each register; all other bits read as zero
  localparam logic [7:0] MASK_IRQ_ENABLE_2  = 8'h01;
  localparam logic [7:0] MASK_PRIO_SELECT_2 = 8'h1f;
  localparam logic [7:0] MASK_A_EDGE        = 8'h0e;
  localparam logic [7:0] MASK_B_EDGE        = 8'h32;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RESET_REG8         = 8'h00;

  // ---------------------------------------------------------------------------
  // Sources, numbered by vector query order (smaller wins)
  // ---------------------------------------------------------------------------
  localparam int         NUM_SRC    = 6;
  localparam logic [2:0] ID_EXT_A   = 3'h0;
  localparam logic [2:0] ID_SERIAL  = 3'h1;
  localparam logic [2:0] ID_PWM     = 3'h2;
  localparam logic [2:0] ID_BASE    = 3'h3;
  localparam logic [2:0] ID_EXT_B   = 3'h4;
  localparam logic [2:0] ID_TOUCH   = 3'h5;

  // Synchroniser plus history depth before edges are trusted
  localparam int         PRIME_STAGES = 3;

  typedef enum logic [3:0] {
    SVC_IDLE   = 4'h1,
    SVC_LOW    = 4'h2,
    SVC_HIGH   = 4'h4,
    SVC_NESTED = 4'h8
  } service_e;

endpackage

// ---- common/ext_edge_if.sv ----
// Carrier between the controller and its pin edge detector.
// Index 0..2 are group A pins 1..3, index 3..5 are group B pins 1, 4 and 5.
interface ext_edge_if;
  logic [5:0] pins;
  logic [5:0] rise_en;
  logic [5:0] fall_en;
  logic [5:0] req;

  modport detector (input pins, input rise_en, input fall_en, output req);
  modport control  (output pins, output rise_en, output fall_en, input req);
endinterface

// ---- rtl/ext_edge_detect.sv ----
// Synchronises the six external interrupt pins and turns enabled edges into pulses.
// Assumes the pins are asynchronous to clk_i and the enables come from clk_i logic.
module ext_edge_detect
  import irq_ctrl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  ext_edge_if.detector    edge_bus
);

  logic [5:0]              sync_1;
  logic [5:0]              sync_2;
  logic [5:0]              prev;
  logic [PRIME_STAGES-1:0] prime_sr;
  logic                    primed;

  // ---------------------------------------------------------------------------
  // Priming
  // ---------------------------------------------------------------------------
  // Reset leaves the history at zero; a pin already high would look like a rising edge
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prime_sr <= '0;
    end else begin
      prime_sr <= {prime_sr[PRIME_STAGES-2:0], 1'b1};
    end
  end

  assign primed = prime_sr[PRIME_STAGES-1];

  // ---------------------------------------------------------------------------
  // Per-pin synchroniser and edge select
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < 6; g++) begin : g_pin
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        sync_1[g] <= 1'b0;
        sync_2[g] <= 1'b0;
        prev[g]   <= 1'b0;
      end else begin
        sync_1[g] <= edge_bus.pins[g]; // RULE15
        sync_2[g] <= sync_1[g];
        prev[g]   <= sync_2[g];
      end
    end

    // RULE8 RULE9 RULE10 RULE11 RULE12
    assign edge_bus.req[g] = primed & ((edge_bus.rise_en[g] & sync_2[g] & ~prev[g]) |
                                       (edge_bus.fall_en[g] & ~sync_2[g] & prev[g]));

    one_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE15
      edge_bus.req[g] |=> !edge_bus.req[g])
      else $error("edge request lasted more than one cycle");
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  sequence a1_rise_s;
    primed && edge_bus.rise_en[0] && !sync_1[0] ##1 sync_1[0] && edge_bus.rise_en[0];
  endsequence

  sequence b5_fall_s;
    primed && edge_bus.fall_en[5] && sync_1[5] ##1 !sync_1[5] && edge_bus.fall_en[5];
  endsequence

  rise_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE9
    a1_rise_s |=> edge_bus.req[0])
    else $error("enabled rising edge on group A pin 1 gave no request");

  fall_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE10
    b5_fall_s |=> edge_bus.req[5])
    else $error("enabled falling edge on group B pin 5 gave no request");

  disarmed_edge_a: assert property (@(posedge clk_i) disable iff (reset_i) // RULE8
    (!edge_bus.rise_en[1] && !edge_bus.fall_en[1]) |-> !edge_bus.req[1])
    else $error("request from a pin with both edges disabled");

endmodule

// ---- tb/core_responder.sv ----
// Behavioural processor core facing the interrupt controller's grant port.
// Assumes registered grant outputs sampled on the rising clock edge.
module core_responder (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       irq_req_i,
  input  wire logic [2:0] irq_id_i,
  input  wire logic       irq_high_i,
  input  wire logic       ack_en_i,
  input  wire logic       auto_ret_i,
  input  wire logic       ret_cmd_i,
  input  wire logic [3:0] ret_dly_i,
  output logic            irq_ack_o,
  output logic            irq_return_o,
  output logic      [2:0] last_id_o,
  output logic            last_high_o,
  output logic      [7:0] grant_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] depth;
  logic [3:0] cnt;
  // ---------------------------------------------------------------------------
  // Vectoring and return
  // ---------------------------------------------------------------------------
  // Never acks and returns together: the controller would lose the ack
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {irq_ack_o, irq_return_o, last_id_o, last_high_o} <= '0;
      grant_cnt_o <= 8'h00;
      depth <= 2'h0;
      cnt <= 4'h0;
    end else begin
      irq_ack_o <= 1'b0;
      irq_return_o <= 1'b0;
      cnt <= (cnt == 4'hf) ? cnt : cnt + 4'h1;
      // A grant counts only at the edge where the controller takes the ack
      if (irq_ack_o && irq_req_i) begin
        last_id_o <= irq_id_i;
        last_high_o <= irq_high_i;
        grant_cnt_o <= grant_cnt_o + 8'h01;
        depth <= depth + 2'h1;
        cnt <= 4'h0;
      end else if (ack_en_i && irq_req_i && !irq_ack_o && !irq_return_o) begin
        irq_ack_o <= 1'b1;
      end else if (!irq_ack_o && depth != 2'h0 && (ret_cmd_i || (auto_ret_i && cnt >= ret_dly_i))) begin
        irq_return_o <= 1'b1;
        depth <= depth - 2'h1;
        cnt <= 4'h0;
      end
    end
  end
endmodule

// ---- tb/ext_irq_edge_priority_ctrl_tb.sv ----
// Self-checking bench for the interrupt control slice.
// Assumes the core_responder model and inputs driven on the falling edge.
module ext_irq_edge_priority_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ahi = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, gcnt;
  logic [2:0] pa = 3'h0, pb = 3'h0, id, lid;
  logic [3:0] preq = 4'h0, dly = 4'h2;
  logic       ack, ret, req, hi, flag, lhi, ack_en = 1'b1, aret = 1'b1, rcmd = 1'b0;
  int         error_cnt = 0, samples_checked = 0;

  always #50 clk = ~clk;

  ext_irq_edge_priority_ctrl dut_u (.clk_i(clk), .reset_i(rst), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .ext_group_a_pin_i(pa),
    .ext_group_b_pin_i(pb), .serial_unit_req_i(preq[0]), .pulse_width_req_i(preq[1]),
    .base_tick_req_i(preq[2]), .touch_sense_req_i(preq[3]), .ext_group_a_high_i(ahi),
    .irq_ack_i(ack), .irq_return_i(ret), .irq_req_o(req), .irq_id_o(id), .irq_high_o(hi),
    .ext_group_a_request_flag_o(flag));
  core_responder core_u (.clk_i(clk), .reset_i(rst), .irq_req_i(req), .irq_id_i(id), .irq_high_i(hi),
    .ack_en_i(ack_en), .auto_ret_i(aret), .ret_cmd_i(rcmd), .ret_dly_i(dly), .irq_ack_o(ack),
    .irq_return_o(ret), .last_id_o(lid), .last_high_o(lhi), .grant_cnt_o(gcnt));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Read data is registered, so it is taken a full cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    check("sfr read", rdata, exp);
  endtask

  task automatic wait_grant(input logic [7:0] old);
    for (int n = 0; n < 40 && gcnt === old; n++) @(negedge clk);
    check("grant count", gcnt, old + 8'h01);
  endtask

  task automatic ret_pulse;
    @(negedge clk);
    rcmd = 1'b1;
    @(negedge clk);
    rcmd = 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic reg_scen;
    logic [7:0] ad [8] = '{8'h88, 8'ha9, 8'hb9, 8'hba, 8'hbb, 8'hc6, 8'hc7, 8'h90};
    logic [7:0] mk [8] = '{8'h02, 8'h01, 8'h1f, 8'h0e, 8'h0e, 8'h32, 8'h32, 8'h00};
    ack_en = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd_chk(ad[i], 8'h00);
      sfr_wr(ad[i], 8'hff);
      rd_chk(ad[i], mk[i]);
      sfr_wr(ad[i], 8'h00);
    end
    ack_en = 1'b1;
  endtask

  task automatic flag_scen;
    ack_en = 1'b0;
    ahi = 1'b1;
    sfr_wr(8'hbb, 8'h02);
    pa[0] = 1'b1;
    repeat (6) @(negedge clk);
    rd_chk(8'h88, 8'h02);
    check("flag out", {7'h0, flag}, 8'h01);
    check("flag grant id", {5'h0, id}, 8'h00);
    check("flag grant level", {7'h0, hi}, 8'h01);
    check("flag grant req", {7'h0, req}, 8'h01);
    ack_en = 1'b1;
    wait_grant(8'h00);
    rd_chk(8'h88, 8'h00);
    pa[0] = 1'b0;
    sfr_wr(8'hbb, 8'h00);
    ahi = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic edge_step(input int g, input int i, input logic v, input logic n);
    logic [7:0] old;
    old = gcnt;
    @(negedge clk);
    if (g == 0) pa[i] = v;
    else pb[i] = v;
    repeat (14) @(negedge clk);
    check("edge grants", gcnt - old, {7'h0, n});
    if (n) begin
      check("edge id", {5'h0, lid}, (g != 0) ? 8'h04 : 8'h00);
      check("edge level", {7'h0, lhi}, (g != 0) ? 8'h01 : 8'h00);
    end
  endtask

  task automatic edge_scen;
    int pos;
    sfr_wr(8'hb9, 8'h08);
    for (int g = 0; g < 2; g++) begin
      for (int i = 0; i < 3; i++) begin
        pos = (g != 0) ? ((i == 0) ? 1 : i + 3) : i + 1;
        // Mode bit 0 arms the rising edge, bit 1 the falling edge
        for (int m = 1; m < 4; m++) begin
          sfr_wr((g != 0) ? 8'hc7 : 8'hbb, m[0] ? 8'h01 << pos : 8'h00);
          sfr_wr((g != 0) ? 8'hc6 : 8'hba, m[1] ? 8'h01 << pos : 8'h00);
          edge_step(g, i, 1'b1, m[0]);
          edge_step(g, i, 1'b0, m[1]);
        end
      end
    end
    sfr_wr(8'hbb, 8'h00);
    sfr_wr(8'hba, 8'h00);
    sfr_wr(8'hc7, 8'h00);
    sfr_wr(8'hc6, 8'h00);
  endtask

  task automatic prio_scen;
    int         bitp [4] = '{0, 1, 2, 4};
    logic [7:0] ids [4] = '{8'h01, 8'h02, 8'h03, 8'h05};
    logic [7:0] old;
    dly = 4'h9;
    sfr_wr(8'hb9, 8'h00);
    old = gcnt;
    preq[0] = 1'b1;
    repeat (10) @(negedge clk);
    check("blocked serial", gcnt, old);
    preq[0] = 1'b0;
    sfr_wr(8'ha9, 8'h01);
    for (int s = 0; s < 4; s++) begin
      for (int h = 0; h < 2; h++) begin
        sfr_wr(8'hb9, (h != 0) ? 8'h01 << bitp[s] : 8'h00);
        old = gcnt;
        preq[s] = 1'b1;
        wait_grant(old);
        preq[s] = 1'b0;
        check("prio id", {5'h0, lid}, ids[s]);
        check("prio level", {7'h0, lhi}, h[7:0]);
        repeat (12) @(negedge clk);
      end
    end
    dly = 4'h2;
  endtask

  task automatic nest_scen;
    logic [7:0] old;
    sfr_wr(8'hb9, 8'h04);
    aret = 1'b0;
    ack_en = 1'b0;
    preq[1] = 1'b1;
    preq[3] = 1'b1;
    repeat (4) @(negedge clk);
    check("tie id", {5'h0, id}, 8'h02);
    old = gcnt;
    ack_en = 1'b1;
    wait_grant(old);
    preq[1] = 1'b0;
    old = gcnt;
    repeat (8) @(negedge clk);
    check("same level waits", gcnt, old);
    preq[2] = 1'b1;
    wait_grant(old);
    preq[2] = 1'b0;
    check("preempt id", {5'h0, lid}, 8'h03);
    ret_pulse();
    old = gcnt;
    repeat (8) @(negedge clk);
    check("low still busy", gcnt, old);
    ret_pulse();
    wait_grant(old);
    preq[3] = 1'b0;
    check("resumed id", {5'h0, lid}, 8'h05);
    ret_pulse();
    aret = 1'b1;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    reg_scen();
    flag_scen();
    edge_scen();
    prio_scen();
    nest_scen();
    give_verdict();
  end

  // Whole run needs under 2000 cycles; allow a wide margin
  initial begin
    #5000000;
    error_cnt++;
    give_verdict();
  end
endmodule
